// [lpdc_pkg.sv]
// constants, opcodes and types of the command decoder
package lpdc_pkg;

  // ==========================================================
  // bus and field widths
  localparam int CA_W    = 10;
  localparam int OPC_W   = 4;
  localparam int BANK_W  = 3;
  localparam int ROW_W   = 15;
  localparam int COL_W   = 12;
  localparam int MR_W    = 8;

  // ==========================================================
  // field positions on the two bus halves
  localparam int MA_LO_LSB  = 4;  // rise half, mode addr bits 0..5
  localparam int MA_LO_W    = 6;
  localparam int MA_HI_LSB  = 0;  // fall half, mode addr bits 6..7
  localparam int MA_HI_W    = 2;
  localparam int OP_LSB     = 2;  // fall half, mode data bits 0..7
  localparam int BANK_LSB   = 7;  // rise half, bank address
  localparam int ROWH_LSB   = 2;  // rise half, row bits 8..12
  localparam int ROWH_W     = 5;
  localparam int ROWL_LSB   = 0;  // fall half, row bits 0..7
  localparam int ROWL_W     = 8;
  localparam int ROW13_BIT  = 8;  // fall half
  localparam int ROW14_BIT  = 9;  // fall half
  localparam int COLL_LSB   = 5;  // rise half, column bits 1..2
  localparam int COLL_W     = 2;
  localparam int AP_BIT     = 0;  // fall half, auto precharge
  localparam int COLH_LSB   = 1;  // fall half, column bits 3..11
  localparam int COLH_W     = 9;
  localparam int AB_BIT     = 4;  // rise half, precharge all banks

  // ==========================================================
  // opcodes on lines 0..3, line 0 in bit 0
  localparam logic [3:0] OPC_MRW    = 4'h0;
  localparam logic [3:0] OPC_MRR    = 4'h8;
  localparam logic [3:0] OPC_REF_PB = 4'h4;
  localparam logic [3:0] OPC_REF_AB = 4'hc;
  localparam logic [1:0] OPC_ACT    = 2'h2;
  localparam logic [2:0] OPC_WR     = 3'h1;
  localparam logic [2:0] OPC_RD     = 3'h5;
  localparam logic [3:0] OPC_PRE    = 4'hb;
  localparam logic [3:0] OPC_BST    = 4'h3;
  localparam logic [2:0] OPC_NOP    = 3'h7;
  localparam logic [2:0] OPC_DPD    = 3'h3;
  localparam logic [2:0] OPC_SREF   = 3'h4;

  // ==========================================================
  // decoded command kinds and power states
  typedef enum logic [3:0] {
    CMD_NONE, CMD_MRW, CMD_MRR, CMD_REF_PB, CMD_REF_AB, CMD_ACT,
    CMD_WR, CMD_RD, CMD_PRE, CMD_BST, CMD_NOP, CMD_PD_ENTER,
    CMD_SREF_ENTER, CMD_DPD_ENTER, CMD_PD_EXIT, CMD_BAD
  } lpdc_cmd_t;

  typedef enum logic [2:0] {
    PWR_ON, PWR_RESETTING, PWR_AWAKE, PWR_PD_ACTIVE, PWR_PD_IDLE,
    PWR_PD_RESET, PWR_SREF, PWR_DPD
  } lpdc_pwr_t;

  // ==========================================================
  // values after reset
  localparam lpdc_pwr_t  PWR_RST  = PWR_ON;
  localparam lpdc_cmd_t  CMD_RST  = CMD_NONE;
  localparam logic       CKE_RST  = 1'b0;
  localparam logic       BIT_RST  = 1'b0;

endpackage

// [lpdc_sync.sv]
// two flip-flop level synchroniser with asynchronous reset
`timescale 1ns/1ps
module lpdc_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic meta;

  // meta feeds only q
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// [lpdc_decoder.sv]
// command and clock-enable decoder of a low-power ddr2 memory
`timescale 1ns/1ps
module lpdc_decoder
  import lpdc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ck_link,
  input  wire logic              cs_n,
  input  wire logic              cke,
  input  wire logic [CA_W-1:0]   ca,
  input  wire logic              eight_bank,
  input  wire logic              banks_active,
  input  wire logic              resetting,
  input  wire logic              init_done,
  output logic                   cmd_valid,
  output lpdc_cmd_t              cmd_kind,
  output logic [BANK_W-1:0]      cmd_bank,
  output logic [ROW_W-1:0]       cmd_row,
  output logic [COL_W-1:0]       cmd_col,
  output logic                   cmd_auto_pre,
  output logic                   cmd_pre_all,
  output logic [MR_W-1:0]        mr_addr,
  output logic [MR_W-1:0]        mr_data,
  output logic                   cmd_illegal,
  output lpdc_pwr_t              power_state,
  output logic                   pwr_exit,
  output logic                   needs_init
);

  // ==========================================================
  // reset release for both domains
  logic rst_n;
  logic lrst_n;

  lpdc_sync u_rst_sys (
    .clk   (clk),
    .rst_n (arst_n),
    .d     (1'b1),
    .q     (rst_n)
  );

  lpdc_sync u_rst_link (
    .clk   (ck_link),
    .rst_n (arst_n),
    .d     (1'b1),
    .q     (lrst_n)
  );

  // ==========================================================
  // decoding helpers
  function automatic lpdc_cmd_t decode_cmd(
    input logic       cs_n_i,
    input logic       cke_p,
    input logic       cke_c,
    input logic [3:0] op
  );
    lpdc_cmd_t k;
    k = CMD_NONE;
    if (!cke_p && !cke_c) begin
      k = CMD_NONE;
    end else if (!cke_p) begin
      k = cs_n_i ? CMD_PD_EXIT : CMD_BAD;
    end else if (!cke_c) begin
      if (cs_n_i) begin
        k = CMD_PD_ENTER;
      end else if (op[2:0] == OPC_DPD) begin
        k = CMD_DPD_ENTER;
      end else if (op[2:0] == OPC_SREF) begin
        k = CMD_SREF_ENTER;
      end else begin
        k = CMD_BAD;
      end
    end else if (cs_n_i) begin
      k = CMD_NOP;
    end else if (op == OPC_MRW) begin
      k = CMD_MRW;
    end else if (op == OPC_MRR) begin
      k = CMD_MRR;
    end else if (op == OPC_REF_PB) begin
      k = CMD_REF_PB;
    end else if (op == OPC_REF_AB) begin
      k = CMD_REF_AB;
    end else if (op[1:0] == OPC_ACT) begin
      k = CMD_ACT;
    end else if (op[2:0] == OPC_WR) begin
      k = CMD_WR;
    end else if (op[2:0] == OPC_RD) begin
      k = CMD_RD;
    end else if (op == OPC_PRE) begin
      k = CMD_PRE;
    end else if (op == OPC_BST) begin
      k = CMD_BST;
    end else if (op[2:0] == OPC_NOP) begin
      k = CMD_NOP;
    end else begin
      k = CMD_BAD;
    end
    return k;
  endfunction

  // self-refresh and deep power-down entry allowed only when awake with all banks idle
  function automatic logic entry_ok(
    input lpdc_pwr_t st,
    input logic      active
  );
    return (st == PWR_AWAKE) && !active;
  endfunction

  // ==========================================================
  // link domain, rising edge: first half and decode
  logic              r_cke_prev;
  lpdc_cmd_t         r_kind;
  logic [CA_W-1:0]   r_ca;
  logic              next_r_cke_prev;
  lpdc_cmd_t         next_r_kind;
  logic [CA_W-1:0]   next_r_ca;

  // cs is only looked at on this edge; cke is also sampled on clk through u_cke_sync
  always_comb begin
    next_r_cke_prev = cke;
    next_r_kind     = decode_cmd(cs_n, r_cke_prev, cke,
                                 ca[OPC_W-1:0]);
    next_r_ca       = ca;
  end

  always_ff @(posedge ck_link or negedge lrst_n) begin
    if (!lrst_n) begin
      r_cke_prev <= CKE_RST;
      r_kind     <= CMD_RST;
      r_ca       <= '0;
    end else begin
      r_cke_prev <= next_r_cke_prev;
      r_kind     <= next_r_kind;
      r_ca       <= next_r_ca;
    end
  end

  // ==========================================================
  // link domain, falling edge: second half and publish
  lpdc_cmd_t         f_kind;
  logic [BANK_W-1:0] f_bank;
  logic [ROW_W-1:0]  f_row;
  logic [COL_W-1:0]  f_col;
  logic              f_ap;
  logic              f_all;
  logic [MR_W-1:0]   f_maddr;
  logic [MR_W-1:0]   f_mdata;
  logic              f_tog;
  lpdc_cmd_t         next_f_kind;
  logic [BANK_W-1:0] next_f_bank;
  logic [ROW_W-1:0]  next_f_row;
  logic [COL_W-1:0]  next_f_col;
  logic              next_f_ap;
  logic              next_f_all;
  logic [MR_W-1:0]   next_f_maddr;
  logic [MR_W-1:0]   next_f_mdata;
  logic              next_f_tog;

  // word is held between publishes so the other side reads it stable
  always_comb begin
    next_f_kind  = f_kind;
    next_f_bank  = f_bank;
    next_f_row   = f_row;
    next_f_col   = f_col;
    next_f_ap    = f_ap;
    next_f_all   = f_all;
    next_f_maddr = f_maddr;
    next_f_mdata = f_mdata;
    next_f_tog   = f_tog;
    if (r_kind != CMD_NONE && r_kind != CMD_NOP) begin
      next_f_kind  = r_kind;
      next_f_tog   = ~f_tog;
      next_f_bank  = '0;                                    // unused fields 0
      next_f_row   = '0;
      next_f_col   = '0;
      next_f_ap    = 1'b0;
      next_f_all   = 1'b0;
      next_f_maddr = '0;
      next_f_mdata = '0;
      unique case (r_kind)
        CMD_MRW, CMD_MRR: begin
          next_f_maddr = {ca[MA_HI_LSB +: MA_HI_W],
                          r_ca[MA_LO_LSB +: MA_LO_W]};
          if (r_kind == CMD_MRW) begin
            next_f_mdata = ca[OP_LSB +: MR_W];
          end
        end
        CMD_ACT: begin
          next_f_bank = r_ca[BANK_LSB +: BANK_W];
          next_f_row = {ca[ROW14_BIT], ca[ROW13_BIT],
                        r_ca[ROWH_LSB +: ROWH_W],
                        ca[ROWL_LSB +: ROWL_W]};
        end
        CMD_WR, CMD_RD: begin
          next_f_bank = r_ca[BANK_LSB +: BANK_W];
          next_f_col = {ca[COLH_LSB +: COLH_W],
                        r_ca[COLL_LSB +: COLL_W], 1'b0};
          next_f_ap  = ca[AP_BIT];
        end
        CMD_PRE: begin
          next_f_bank = r_ca[BANK_LSB +: BANK_W];
          next_f_all = r_ca[AB_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(negedge ck_link or negedge lrst_n) begin
    if (!lrst_n) begin
      f_kind  <= CMD_RST;
      f_bank  <= '0;
      f_row   <= '0;
      f_col   <= '0;
      f_ap    <= BIT_RST;
      f_all   <= BIT_RST;
      f_maddr <= '0;
      f_mdata <= '0;
      f_tog   <= BIT_RST;
    end else begin
      f_kind  <= next_f_kind;
      f_bank  <= next_f_bank;
      f_row   <= next_f_row;
      f_col   <= next_f_col;
      f_ap    <= next_f_ap;
      f_all   <= next_f_all;
      f_maddr <= next_f_maddr;
      f_mdata <= next_f_mdata;
      f_tog   <= next_f_tog;
    end
  end

  // ==========================================================
  // crossings into the system clock
  logic tog_s;
  logic cke_s;

  lpdc_sync u_tog_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (f_tog),
    .q     (tog_s)
  );

  // cke level watched without the link clock
  lpdc_sync u_cke_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (cke),
    .q     (cke_s)
  );

  // ==========================================================
  // system domain: command capture
  logic              tog_d;
  logic              evt;
  logic              next_tog_d;
  logic              next_cmd_valid;
  lpdc_cmd_t         next_cmd_kind;
  logic [BANK_W-1:0] next_cmd_bank;
  logic [ROW_W-1:0]  next_cmd_row;
  logic [COL_W-1:0]  next_cmd_col;
  logic              next_cmd_auto_pre;
  logic              next_cmd_pre_all;
  logic [MR_W-1:0]   next_mr_addr;
  logic [MR_W-1:0]   next_mr_data;
  logic              next_cmd_illegal;

  assign evt = tog_s ^ tog_d;

  // one pulse per published command, fields held until the next
  always_comb begin
    next_tog_d        = tog_s;
    next_cmd_valid    = evt;
    next_cmd_kind     = cmd_kind;
    next_cmd_bank     = cmd_bank;
    next_cmd_row      = cmd_row;
    next_cmd_col      = cmd_col;
    next_cmd_auto_pre = cmd_auto_pre;
    next_cmd_pre_all  = cmd_pre_all;
    next_mr_addr      = mr_addr;
    next_mr_data      = mr_data;
    next_cmd_illegal  = 1'b0;
    if (evt) begin
      next_cmd_kind     = f_kind;
      next_cmd_bank     = f_bank;
      next_cmd_row      = f_row;
      next_cmd_col      = f_col;
      next_cmd_auto_pre = f_ap;
      next_cmd_pre_all  = f_all;
      next_mr_addr      = f_maddr;
      next_mr_data      = f_mdata;
      next_cmd_illegal  = (f_kind == CMD_BAD) ||
                          (f_kind == CMD_REF_PB && !eight_bank) ||
                          ((f_kind == CMD_SREF_ENTER ||
                            f_kind == CMD_DPD_ENTER) &&
                           !entry_ok(power_state, banks_active));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_d        <= BIT_RST;
      cmd_valid    <= BIT_RST;
      cmd_kind     <= CMD_RST;
      cmd_bank     <= '0;
      cmd_row      <= '0;
      cmd_col      <= '0;
      cmd_auto_pre <= BIT_RST;
      cmd_pre_all  <= BIT_RST;
      mr_addr      <= '0;
      mr_data      <= '0;
      cmd_illegal  <= BIT_RST;
    end else begin
      tog_d        <= next_tog_d;
      cmd_valid    <= next_cmd_valid;
      cmd_kind     <= next_cmd_kind;
      cmd_bank     <= next_cmd_bank;
      cmd_row      <= next_cmd_row;
      cmd_col      <= next_cmd_col;
      cmd_auto_pre <= next_cmd_auto_pre;
      cmd_pre_all  <= next_cmd_pre_all;
      mr_addr      <= next_mr_addr;
      mr_data      <= next_mr_data;
      cmd_illegal  <= next_cmd_illegal;
    end
  end

  // ==========================================================
  // system domain: power state
  lpdc_pwr_t next_power_state;
  logic      next_pwr_exit;
  logic      next_needs_init;
  logic      bad_evt;

  assign bad_evt = next_cmd_illegal;

  // entry and exit of the low-power states
  always_comb begin
    next_power_state = power_state;
    next_pwr_exit    = 1'b0;
    next_needs_init  = needs_init;
    unique case (power_state)
      PWR_ON: begin
        if (resetting) begin
          next_power_state = PWR_RESETTING;
        end
      end
      PWR_RESETTING: begin
        if (evt && f_kind == CMD_PD_ENTER) begin
          next_power_state = PWR_PD_RESET;
        end else if (init_done) begin
          next_power_state = PWR_AWAKE;
        end
      end
      PWR_AWAKE: begin
        if (evt && f_kind == CMD_PD_ENTER) begin
          next_power_state = banks_active ? PWR_PD_ACTIVE
                                          : PWR_PD_IDLE;
        end else if (evt && !bad_evt &&
                     f_kind == CMD_SREF_ENTER) begin
          next_power_state = PWR_SREF;
        end else if (evt && !bad_evt &&
                     f_kind == CMD_DPD_ENTER) begin
          next_power_state = PWR_DPD;
        end
      end
      PWR_PD_ACTIVE, PWR_PD_IDLE: begin
        if (evt && f_kind == CMD_PD_EXIT) begin
          next_power_state = PWR_AWAKE;
          next_pwr_exit    = 1'b1;
        end
      end
      PWR_PD_RESET: begin
        if (evt && f_kind == CMD_PD_EXIT) begin
          next_power_state = init_done ? PWR_AWAKE
                                       : PWR_RESETTING;
          next_pwr_exit    = 1'b1;
        end
      end
      PWR_SREF: begin
        if (cke_s) begin
          next_power_state = PWR_AWAKE;
          next_pwr_exit    = 1'b1;
        end
      end
      PWR_DPD: begin
        if (cke_s) begin
          next_power_state = PWR_ON;
          next_pwr_exit    = 1'b1;
        end
      end
    endcase
    // set wins over the clear by resetting
    if (bad_evt || (power_state == PWR_DPD && cke_s)) begin
      next_needs_init = 1'b1;
    end else if (resetting) begin
      next_needs_init = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_state <= PWR_RST;
      pwr_exit    <= BIT_RST;
      needs_init  <= BIT_RST;
    end else begin
      power_state <= next_power_state;
      pwr_exit    <= next_pwr_exit;
      needs_init  <= next_needs_init;
    end
  end

endmodule

// [lpdc_decoder_props.sv]
// assertion checker watching the command decoder ports
`timescale 1ns/1ps
module lpdc_decoder_props
  import lpdc_pkg::*;
(
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic              cke,
  input wire logic              banks_active,
  input wire logic              cmd_valid,
  input wire lpdc_cmd_t         cmd_kind,
  input wire logic [BANK_W-1:0] cmd_bank,
  input wire logic [ROW_W-1:0]  cmd_row,
  input wire logic [COL_W-1:0]  cmd_col,
  input wire logic              cmd_auto_pre,
  input wire logic              cmd_pre_all,
  input wire logic [MR_W-1:0]   mr_addr,
  input wire logic [MR_W-1:0]   mr_data,
  input wire logic              cmd_illegal,
  input wire lpdc_pwr_t         power_state,
  input wire logic              pwr_exit,
  input wire logic              needs_init
);
  // ====================
  // helpers
  logic [51:0] flds;

  // all published command fields in one vector
  assign flds = {cmd_kind, cmd_bank, cmd_row, cmd_col, cmd_auto_pre,
                 cmd_pre_all, mr_addr, mr_data};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // cke seen high for four clk samples, the first of them in the sleep state st
  sequence s_up(lpdc_pwr_t st);
    (cke && power_state == st) ##1 cke [*3];
  endsequence

  // ====================
  // command publication
  a_valid_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe longer than one cycle");
  a_fields_hold: assert property (!cmd_valid |-> $stable(flds))
    else $error("fields changed without a strobe");
  a_col_lsb: assert property (cmd_col[0] == 1'b0)
    else $error("column bit zero not clear");
  a_ill_pulse: assert property (cmd_illegal |-> cmd_valid)
    else $error("illegal flag without a strobe");
  a_pre_only: assert property (cmd_pre_all |-> cmd_kind == CMD_PRE)
    else $error("all-bank flag outside precharge");
  a_ap_only: assert property (
    cmd_auto_pre |-> cmd_kind inside {CMD_RD, CMD_WR})
    else $error("auto precharge outside read or write");

  // ====================
  // power states
  a_pd_enter: assert property (
    cmd_valid && cmd_kind == CMD_PD_ENTER && $past(power_state) == PWR_AWAKE
    |-> power_state == (banks_active ? PWR_PD_ACTIVE : PWR_PD_IDLE))
    else $error("power-down entry went to the wrong state");
  a_pd_exit: assert property (
    cmd_valid && cmd_kind == CMD_PD_EXIT &&
    $past(power_state) inside {PWR_PD_IDLE, PWR_PD_ACTIVE}
    |-> power_state == PWR_AWAKE)
    else $error("power-down exit did not wake");
  a_pd_keep: assert property (
    cmd_valid && $past(power_state) inside {PWR_PD_IDLE, PWR_PD_ACTIVE}
    |-> cmd_kind inside {CMD_PD_EXIT, CMD_BAD})
    else $error("command decoded during power-down");
  a_exit_pulse: assert property (pwr_exit |=> !pwr_exit)
    else $error("exit strobe longer than one cycle");
  a_sref_exit: assert property (
    s_up(PWR_SREF) |-> ##[0:2] power_state == PWR_AWAKE)
    else $error("self refresh not left on cke high");
  a_dpd_exit: assert property (
    s_up(PWR_DPD) |-> ##[0:2] (power_state == PWR_ON && needs_init))
    else $error("deep power-down not left on cke high");
endmodule

// [lpdc_ctrl_model.sv]
// memory controller model driving link clock, select, enable and bus
`timescale 1ns/1ps
module lpdc_ctrl_model (
  output logic       ck_link,
  output logic       cs_n,
  output logic       cke,
  output logic [9:0] ca
);
  // ====================
  // free running link clock, phase unrelated to clk
  initial begin
    ck_link = 1'b0;
    cs_n    = 1'b1;
    cke     = 1'b0;
    ca      = 10'h155;
    #7;
    forever #32 ck_link = ~ck_link;
  end

  // ====================
  // one specified command, then deselect (nop) cycles
  task automatic send(input logic s, input logic e,
                      input logic [9:0] r, input logic [9:0] f);
    @(negedge ck_link);
    #2;
    cs_n = s;  // select and enable for the rising edge
    cke  = e;
    ca   = r;
    @(posedge ck_link);
    #2;
    cs_n = ~s;  // select is don't-care in the fall half
    ca   = f;
    @(negedge ck_link);
    #2;
    cs_n = 1'b1;  // only nops follow an exit
    ca   = ~f;
  endtask
endmodule

// [lpdc_decoder_tb.sv]
// self-checking testbench of the command decoder
`timescale 1ns/1ps
module lpdc_decoder_tb;
  import lpdc_pkg::*;
  logic              clk, arst_n, ck_link, cs_n, cke, eight_bank;
  logic              banks_active, resetting, init_done, cmd_valid;
  logic              cmd_auto_pre, cmd_pre_all, cmd_illegal, pwr_exit;
  logic              needs_init, ev_ill;
  logic [CA_W-1:0]   ca;
  logic [BANK_W-1:0] cmd_bank;
  logic [ROW_W-1:0]  cmd_row;
  logic [COL_W-1:0]  cmd_col;
  logic [MR_W-1:0]   mr_addr, mr_data;
  lpdc_cmd_t         cmd_kind;
  lpdc_pwr_t         power_state;
  logic [63:0]       seen_fl;
  int                n_mismatch, samples_checked, n_evt, n_exit, n0;

  assign seen_fl = {12'h0, cmd_kind, cmd_bank, cmd_row, cmd_col,
                    cmd_auto_pre, cmd_pre_all, mr_addr, mr_data};

  lpdc_ctrl_model u_ctrl (.ck_link(ck_link), .cs_n(cs_n), .cke(cke),
                          .ca(ca));

  lpdc_decoder dut_u (
    .clk(clk), .arst_n(arst_n), .ck_link(ck_link), .cs_n(cs_n),
    .cke(cke), .ca(ca), .eight_bank(eight_bank),
    .banks_active(banks_active), .resetting(resetting),
    .init_done(init_done), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_bank(cmd_bank), .cmd_row(cmd_row), .cmd_col(cmd_col),
    .cmd_auto_pre(cmd_auto_pre), .cmd_pre_all(cmd_pre_all),
    .mr_addr(mr_addr), .mr_data(mr_data), .cmd_illegal(cmd_illegal),
    .power_state(power_state), .pwr_exit(pwr_exit),
    .needs_init(needs_init));

  // ====================
  // clock, event counters, watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // count strobes and keep the illegal flag of the last one
  always @(negedge clk) begin
    if (cmd_valid === 1'b1) begin
      n_evt++;
      ev_ill = cmd_illegal;
    end
    if (pwr_exit === 1'b1)
      n_exit++;
  end

  // cut a hang short
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end

  // ====================
  // tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [63:0] fl(lpdc_cmd_t k, logic [2:0] b,
    logic [14:0] r, logic [11:0] c, logic ap, logic ab, logic [15:0] m);
    return {12'h0, k, b, r, c, ap, ab, m};
  endfunction

  task automatic run(input logic s, input logic e, input logic [9:0] r,
                     input logic [9:0] f, input int ev);
    int n;
    n = n_evt;
    u_ctrl.send(s, e, r, f);
    repeat (8) @(posedge clk);
    check(n_evt - n, ev);
  endtask

  task automatic cc(input logic [9:0] r, input logic [9:0] f,
                    input logic [63:0] e);
    run(1'b0, 1'b1, r, f, 1);
    check(seen_fl, e);
    check(ev_ill, 1'b0);
  endtask

  task automatic restart();
    @(posedge clk) resetting <= 1'b1;
    @(posedge clk) resetting <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ====================
  // test sequence
  initial begin
    {eight_bank, banks_active, resetting, init_done} <= 4'h8;
    arst_n <= 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (20) @(posedge clk);
    run(1, 1, 0, 0, 1);
    restart();
    check(power_state, PWR_RESETTING);
    run(1, 0, 0, 0, 1);
    check(power_state, PWR_PD_RESET);
    run(1, 1, 0, 0, 1);
    check(power_state, PWR_RESETTING);
    @(posedge clk) init_done <= 1'b1;
    repeat (3) @(posedge clk);
    check(power_state, PWR_AWAKE);
    cc({6'h25, 4'h0}, {8'h3c, 2'h2},
       fl(CMD_MRW, 0, 0, 0, 0, 0, 16'ha53c));
    cc({6'h1a, 4'h8}, 10'h3fd, fl(CMD_MRR, 0, 0, 0, 0, 0, 16'h5a00));
    cc(10'h004, 10'h000, fl(CMD_REF_PB, 0, 0, 0, 0, 0, 0));
    cc(10'h00c, 10'h000, fl(CMD_REF_AB, 0, 0, 0, 0, 0, 0));
    cc({3'h5, 5'h0d, 2'h2}, {2'h3, 8'h39},
       fl(CMD_ACT, 3'h5, 15'h6d39, 0, 0, 0, 0));
    cc({3'h3, 2'h3, 2'h3, 3'h1}, {9'h156, 1'h1},
       fl(CMD_WR, 3'h3, 0, 12'hab6, 1, 0, 0));
    cc({3'h6, 2'h0, 2'h3, 3'h5}, {9'h0a9, 1'h0},
       fl(CMD_RD, 3'h6, 0, 12'h548, 0, 0, 0));
    cc({3'h0, 2'h3, 1'h1, 4'hb}, 10'h3ff,
       fl(CMD_PRE, 0, 0, 0, 0, 1, 0));
    cc({3'h2, 2'h3, 1'h0, 4'hb}, 10'h3ff,
       fl(CMD_PRE, 3'h2, 0, 0, 0, 0, 0));
    cc(10'h003, 10'h000, fl(CMD_BST, 0, 0, 0, 0, 0, 0));
    run(0, 1, 10'h3f7, 10'h3ff, 0);
    run(1, 1, 10'h000, 10'h000, 0);
    @(posedge clk) eight_bank <= 1'b0;
    run(0, 1, 10'h004, 10'h000, 1);
    check(ev_ill, 1'b1);
    @(posedge clk) eight_bank <= 1'b1;
    // idle then active power-down, with a masked command while asleep
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) banks_active <= i[0];
      n0 = n_exit;
      run(1, 0, 0, 0, 1);
      check(power_state, i ? PWR_PD_ACTIVE : PWR_PD_IDLE);
      run(0, 0, 0, 0, 0);
      check(power_state, i ? PWR_PD_ACTIVE : PWR_PD_IDLE);
      run(1, 1, 0, 0, 1);
      check(power_state, PWR_AWAKE);
      check(n_exit - n0, 1);
    end
    run(0, 0, 10'h004, 0, 1);
    check({power_state, ev_ill}, {PWR_AWAKE, 1'b1});
    run(1, 1, 0, 0, 1);
    @(posedge clk) banks_active <= 1'b0;
    run(0, 0, 10'h004, 0, 1);
    check(power_state, PWR_SREF);
    run(1, 1, 0, 0, 1);
    check(power_state, PWR_AWAKE);
    run(0, 0, 10'h003, 0, 1);
    check(power_state, PWR_DPD);
    run(1, 1, 0, 0, 1);
    check({power_state, needs_init}, {PWR_ON, 1'b1});
    restart();
    check({power_state, needs_init}, {PWR_AWAKE, 1'b0});
    run(0, 0, 0, 0, 1);
    check({cmd_kind, ev_ill, needs_init}, {CMD_BAD, 2'h3});
    run(1, 1, 0, 0, 1);
    finish_test();
  end
endmodule

bind lpdc_decoder lpdc_decoder_props u_props (
  .clk(clk), .arst_n(arst_n), .cke(cke), .banks_active(banks_active),
  .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_bank(cmd_bank),
  .cmd_row(cmd_row), .cmd_col(cmd_col), .cmd_auto_pre(cmd_auto_pre),
  .cmd_pre_all(cmd_pre_all), .mr_addr(mr_addr), .mr_data(mr_data),
  .cmd_illegal(cmd_illegal), .power_state(power_state),
  .pwr_exit(pwr_exit), .needs_init(needs_init));
